// ==== common/ibr_params.svh ====
// constants for the two-wire slave protocol engine with bus recovery
// assumes the includer compiles it once per unit; definitions only
//
// Summary of operation
// - recovery resets only protocol state; committed write data stays untouched.
// - a Start seen anywhere sends the engine back to expecting an address byte.
// - high data line in read acknowledge slot: release bus, reset protocol state.
// - second Start drops partly received write; no write cycle begins.
// - Stop ends all bus activity; engine idles until the next Start.
`ifndef IBR_PARAMS_SVH
`define IBR_PARAMS_SVH

// slave address, arbitrary value
`define IBR_DEV_ADDR 7'h2a
`define IBR_BIT_LAST 3'h7
`define IBR_BIT_FIRST 3'h0
// in the address and write-data states the stop's own clock rise shifts in one bit before the stop is seen
`define IBR_BIT_STOP 3'h1
`define IBR_MAX_BYTES 2'h3
`define IBR_RD_IDX_LAST 2'h2
`define IBR_RD_IDX_FIRST 2'h0
`define IBR_RW_READ 1'b1

`endif

// ==== common/ibr_pkg.sv ====
// types shared by the protocol engine and its line conditioner
// assumes ibr_params.svh supplies the numeric constants
package ibr_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_WDATA,
        ST_WACK,
        ST_RDATA,
        ST_RACK
    } ibr_state_e;

    // one completed write: bytes in arrival order, data[0] first
    typedef struct packed {
        logic [1:0] count;
        logic [2:0][7:0] data;
    } ibr_wr_s;

    // conditioned bus levels and events, all on clk
    typedef struct packed {
        logic scl;
        logic sda;
        logic scl_rise;
        logic scl_fall;
        logic start;
        logic stop;
    } ibr_bus_ev_s;

endpackage : ibr_pkg

// ==== hdl/ibr_line_sync.sv ====
// brings the serial clock and data pins into clk and finds their events
// assumes both pins are asynchronous to clk and slower than clk by far
`timescale 1ns/1ps
module ibr_line_sync
    import ibr_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic rst, // async reset, high
    input wire logic scl_i, // serial clock pin level
    input wire logic sda_i, // serial data pin level
    output ibr_bus_ev_s ev // synchronised levels and events
);

    logic scl_m_q;
    logic scl_s_q;
    logic scl_d_q;
    logic sda_m_q;
    logic sda_s_q;
    logic sda_d_q;

    // idle bus is high, so reset to high to avoid a false event
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            scl_m_q <= 1'b1;
            scl_s_q <= 1'b1;
            scl_d_q <= 1'b1;
            sda_m_q <= 1'b1;
            sda_s_q <= 1'b1;
            sda_d_q <= 1'b1;
        end else begin
            scl_m_q <= scl_i;
            scl_s_q <= scl_m_q;
            scl_d_q <= scl_s_q;
            sda_m_q <= sda_i;
            sda_s_q <= sda_m_q;
            sda_d_q <= sda_s_q;
        end
    end

    wire sda_fell = sda_d_q & ~sda_s_q;
    wire sda_rose = ~sda_d_q & sda_s_q;
    wire scl_high = scl_s_q & scl_d_q;

    assign ev.scl = scl_s_q;
    assign ev.sda = sda_s_q;
    assign ev.scl_rise = scl_s_q & ~scl_d_q;
    assign ev.scl_fall = ~scl_s_q & scl_d_q;
    assign ev.start = scl_high & sda_fell;
    assign ev.stop = scl_high & sda_rose;

endmodule : ibr_line_sync

// ==== hdl/ibr_slave_engine.sv ====
// two-wire slave protocol engine that honours the bus recovery sequence
// assumes an external open-drain pad built from sda_o/sda_oe and pull-ups;
// never stretches the serial clock, so the clock pin is input only
`timescale 1ns/1ps
`include "ibr_params.svh"
module ibr_slave_engine
    import ibr_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = `IBR_DEV_ADDR
)
(
    input wire logic clk, // system clock, 100 MHz
    input wire logic rst, // async reset, high
    input wire logic scl_i, // serial clock pin
    input wire logic sda_i, // serial data pin level
    output logic sda_o, // data pin drive value, always low
    output logic sda_oe, // high while pulling data low
    input wire logic [2:0][7:0] rd_data, // bytes returned on a read
    output ibr_wr_s wr_cmd, // last committed write
    output logic wr_commit, // one-cycle pulse: write cycle begins
    output logic busy // protocol engine not idle
);

    ibr_bus_ev_s ev;
    ibr_state_e state_q;
    ibr_state_e state_d;
    logic [2:0] cnt_q;
    logic [2:0] cnt_d;
    logic [7:0] shift_q;
    logic [7:0] shift_d;
    logic done_q;
    logic done_d;
    logic oe_q;
    logic oe_d;
    logic rw_q;
    logic rw_d;
    logic [1:0] rd_idx_q;
    logic [1:0] rd_idx_d;
    ibr_wr_s pend_q;
    ibr_wr_s pend_d;
    ibr_wr_s cmd_q;
    ibr_wr_s cmd_d;
    logic commit_q;
    logic commit_d;

    ibr_line_sync u_sync (
        .clk(clk),
        .rst(rst),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .ev(ev)
    );

    wire addr_hit = (shift_q[7:1] == DEV_ADDR);
    wire last_bit = (cnt_q == `IBR_BIT_LAST);
    wire pend_full = (pend_q.count == `IBR_MAX_BYTES);
    wire [1:0] rd_idx_next = (rd_idx_q == `IBR_RD_IDX_LAST) ? `IBR_RD_IDX_FIRST : rd_idx_q + 2'h1;
    wire [7:0] rd_byte = rd_data[rd_idx_q];
    wire [7:0] rd_first = rd_data[`IBR_RD_IDX_FIRST];
    // only whole bytes on an unbroken write may start a write cycle;
    // whole bytes plus the stop's clock rise leave exactly one bit counted
    wire wr_complete = (state_q == ST_WDATA) && (cnt_q == `IBR_BIT_STOP) && !done_q
                       && (pend_q.count != 2'h0);

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        shift_d = shift_q;
        done_d = done_q;
        oe_d = oe_q;
        rw_d = rw_q;
        rd_idx_d = rd_idx_q;
        pend_d = pend_q;
        cmd_d = cmd_q;
        commit_d = 1'b0;
        if (ev.start) begin
            state_d = ST_ADDR;
            cnt_d = `IBR_BIT_FIRST;
            done_d = 1'b0;
            oe_d = 1'b0;
            pend_d = '0;
        end else if (ev.stop) begin
            if (wr_complete) begin
                commit_d = 1'b1;
                cmd_d = pend_q;
            end
            state_d = ST_IDLE;
            done_d = 1'b0;
            oe_d = 1'b0;
            pend_d = '0;
        end else if (ev.scl_rise) begin
            case (state_q)
                ST_ADDR, ST_WDATA: begin
                    shift_d = {shift_q[6:0], ev.sda};
                    cnt_d = 3'(cnt_q + 3'h1);
                    if (last_bit) begin
                        done_d = 1'b1;
                    end
                end
                ST_RACK: begin
                    if (ev.sda) begin
                        state_d = ST_IDLE;
                        oe_d = 1'b0;
                    end else begin
                        done_d = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end else if (ev.scl_fall) begin
            case (state_q)
                ST_ADDR: begin
                    if (done_q) begin
                        done_d = 1'b0;
                        if (addr_hit) begin
                            oe_d = 1'b1;
                            rw_d = shift_q[0];
                            state_d = ST_ADDR_ACK;
                        end else begin
                            // not ours: sit quietly until the next start
                            state_d = ST_IDLE;
                        end
                    end
                end
                ST_WDATA: begin
                    if (done_q) begin
                        done_d = 1'b0;
                        if (pend_full) begin
                            // no room: refuse by leaving the ack slot high
                            state_d = ST_IDLE;
                            pend_d = '0;
                        end else begin
                            pend_d.data[pend_q.count] = shift_q;
                            pend_d.count = 2'(pend_q.count + 2'h1);
                            oe_d = 1'b1;
                            state_d = ST_WACK;
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    cnt_d = `IBR_BIT_FIRST;
                    if (rw_q == `IBR_RW_READ) begin
                        shift_d = rd_first;
                        oe_d = ~rd_first[7];
                        rd_idx_d = 2'h1;
                        state_d = ST_RDATA;
                    end else begin
                        oe_d = 1'b0;
                        state_d = ST_WDATA;
                    end
                end
                ST_WACK: begin
                    oe_d = 1'b0;
                    state_d = ST_WDATA;
                end
                ST_RDATA: begin
                    if (last_bit) begin
                        // release for the master's acknowledge slot
                        oe_d = 1'b0;
                        state_d = ST_RACK;
                    end else begin
                        cnt_d = 3'(cnt_q + 3'h1);
                        shift_d = {shift_q[6:0], 1'b0};
                        oe_d = ~shift_q[6];
                    end
                end
                ST_RACK: begin
                    if (done_q) begin
                        done_d = 1'b0;
                        cnt_d = `IBR_BIT_FIRST;
                        shift_d = rd_byte;
                        oe_d = ~rd_byte[7];
                        rd_idx_d = rd_idx_next;
                        state_d = ST_RDATA;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_IDLE;
            cnt_q <= `IBR_BIT_FIRST;
            shift_q <= 8'h00;
            done_q <= 1'b0;
            oe_q <= 1'b0;
            rw_q <= 1'b0;
            rd_idx_q <= `IBR_RD_IDX_FIRST;
            pend_q <= '0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            shift_q <= shift_d;
            done_q <= done_d;
            oe_q <= oe_d;
            rw_q <= rw_d;
            rd_idx_q <= rd_idx_d;
            pend_q <= pend_d;
        end
    end

    // committed data changes only on a good stop
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cmd_q <= '0;
            commit_q <= 1'b0;
        end else begin
            cmd_q <= cmd_d;
            commit_q <= commit_d;
        end
    end

    assign sda_o = 1'b0;
    assign sda_oe = oe_q;
    assign wr_cmd = cmd_q;
    assign wr_commit = commit_q;
    assign busy = (state_q != ST_IDLE);

endmodule : ibr_slave_engine

// ==== test/ibr_engine_asserts.sv ====
// port checks for the slave protocol engine
// assumes one clk domain and a bind onto ibr_slave_engine
`timescale 1ns/1ps
module ibr_engine_asserts
    import ibr_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic rst, // async reset
    input wire logic scl_i, // clock pin
    input wire logic sda_i, // data pin
    input wire logic sda_o, // drive value
    input wire logic sda_oe, // drive enable
    input ibr_wr_s wr_cmd, // last write
    input wire logic wr_commit, // write pulse
    input wire logic busy // engine busy
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    sequence s_start;
        scl_i && $past(scl_i) && $fell(sda_i);
    endsequence
    sequence s_stop;
        scl_i && $past(scl_i) && $rose(sda_i);
    endsequence
    chk_start_wakes: assert property (s_start |-> ##[2:5] busy)
        else $error("engine not busy after start");
    chk_stop_idles: assert property (s_stop |-> ##[2:6] !busy)
        else $error("engine busy after stop");
    chk_idle_quiet: assert property (!busy |-> !sda_oe)
        else $error("idle engine drives data");
    chk_oe_clock_low: assert property ($changed(sda_oe) |-> !scl_i)
        else $error("data drive changed with clock high");
    chk_commit_stop: assert property (wr_commit |-> scl_i && sda_i && wr_cmd.count != 2'h0)
        else $error("commit without stop or data");
    chk_commit_idle: assert property (wr_commit |-> !busy ##1 !wr_commit)
        else $error("commit not a lone idle pulse");
    // stored write only moves on commit
    chk_cmd_hold: assert property ($changed(wr_cmd) |-> wr_commit)
        else $error("stored write changed without commit");
    chk_drive_low: assert property (sda_oe |-> !sda_o)
        else $error("data driven high");
endmodule : ibr_engine_asserts

bind ibr_slave_engine ibr_engine_asserts u_chk (.clk(clk), .rst(rst), .scl_i(scl_i), .sda_i(sda_i),
    .sda_o(sda_o), .sda_oe(sda_oe), .wr_cmd(wr_cmd), .wr_commit(wr_commit), .busy(busy));

// ==== test/ibr_host_model.sv ====
// host master model for the two-wire link
// assumes a pull-up on data; clock idles high between frames
`timescale 1ns/1ps
module ibr_host_model (
    output logic scl, // serial clock
    output logic sda_low, // high pulls data low
    input wire logic sda // resolved data wire
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // every pin change lands between clk edges; task lengths keep that phase
    // start, data falls with clock high
    task start_c;
        #21.25 sda_low = 1'b0;
        #42.5 scl = 1'b1;
        #62.5 sda_low = 1'b1;
        #60 scl = 1'b0;
        #3.75;
    endtask : start_c
    task stop_c;
        #21.25 sda_low = 1'b1;
        #42.5 scl = 1'b1;
        #62.5 sda_low = 1'b0;
        #63.75;
    endtask : stop_c
    // data moves only while clock low
    task bit_io(input logic b, output logic v);
        #21.25 sda_low = ~b;
        #42.5 scl = 1'b1;
        #31 v = sda;
        #29 scl = 1'b0;
        #1.25;
    endtask : bit_io
    task byte_io(input logic [7:0] d, input logic a, output logic [7:0] q, output logic k);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], q[i]);
        end
        bit_io(a, k);
    endtask : byte_io
endmodule : ibr_host_model

// ==== test/i2c_bus_recovery_reset_tb.sv ====
// bench: host model on the link; write, read and recovery
// assumes the host model and the bound checker are compiled
`timescale 1ns/1ps
`include "ibr_params.svh"
module i2c_bus_recovery_reset_tb;
    import ibr_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0][7:0] rd_data = '0;
    logic scl, sda_low, sda_o, sda_oe, wr_commit, busy, k;
    logic [7:0] q;
    logic [8:0] v;
    ibr_wr_s wr_cmd;
    int bad_count = 0;
    int checks_done = 0;
    int cyc = 0;
    int commits = 0;
    // pull-up wins unless the host or the engine's driver pulls low
    wire sda = sda_low ? 1'b0 : (sda_oe ? sda_o : 1'b1);
    always #5 clk = ~clk;
    ibr_host_model mdl (.scl(scl), .sda_low(sda_low), .sda(sda));
    ibr_slave_engine DUT (.clk(clk), .rst(rst), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
        .rd_data(rd_data), .wr_cmd(wr_cmd), .wr_commit(wr_commit), .busy(busy));
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (wr_commit === 1'b1)
            commits <= commits + 1;
        if (cyc == 20000) begin
            bad_count = bad_count + 1;
            close_out();
        end
    end
    task chk(input logic [81:0] got, input logic [81:0] exp, input string m);
        checks_done = checks_done + 1;
        if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask : chk
    task close_out;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : close_out
    task recover;
        mdl.start_c();
        for (int i = 8; i >= 0; i--) begin
            mdl.bit_io(1'b1, v[i]);
        end
        mdl.start_c();
        mdl.stop_c();
        repeat (8) @(negedge clk);
    endtask : recover
    task t_write(input logic [2:0][7:0] d);
        int c0;
        c0 = commits;
        mdl.start_c();
        mdl.byte_io({`IBR_DEV_ADDR, 1'b0}, 1'b1, q, k);
        chk(k, 1'b0, "address not acked");
        for (int i = 0; i < 3; i++) begin
            mdl.byte_io(d[i], 1'b1, q, k);
        end
        mdl.stop_c();
        repeat (8) @(negedge clk);
        chk(commits - c0, 1, "commit count");
        chk(wr_cmd, {2'h3, d}, "write data");
        $display("write test done");
    endtask : t_write
    task t_rec_read;
        @(negedge clk);
        rd_data = {8'h5a, 8'hc3, 8'h3c};
        mdl.start_c();
        mdl.byte_io({`IBR_DEV_ADDR, 1'b1}, 1'b1, q, k);
        mdl.byte_io(8'hff, 1'b0, q, k);
        chk(q, 8'h3c, "read byte");
        mdl.bit_io(1'b1, k);
        mdl.bit_io(1'b1, k);
        repeat (6) @(negedge clk);
        chk(sda, 1'b0, "slave not holding data");
        recover();
        chk(v, 9'h03f, "recovery bits");
        chk({busy, sda_oe}, 2'h0, "bus not released");
        $display("read recovery test done");
    endtask : t_rec_read
    task t_rec_write;
        mdl.start_c();
        mdl.byte_io({`IBR_DEV_ADDR, 1'b0}, 1'b1, q, k);
        mdl.byte_io(8'h11, 1'b1, q, k);
        recover();
        chk(v, 9'h1ff, "data held in recovery");
        chk(commits, 1, "write cycle began");
        chk(wr_cmd, {2'h3, 8'h0f, 8'ha3, 8'h55}, "stored write changed");
        chk(busy, 1'b0, "busy after stop");
        $display("write recovery test done");
    endtask : t_rec_write
    task t_refuse;
        int c0;
        c0 = commits;
        mdl.start_c();
        mdl.byte_io({`IBR_DEV_ADDR ^ 7'h01, 1'b0}, 1'b1, q, k);
        chk(k, 1'b1, "foreign address acked");
        mdl.stop_c();
        mdl.start_c();
        mdl.byte_io({`IBR_DEV_ADDR, 1'b0}, 1'b1, q, k);
        for (int i = 0; i < 4; i++) begin
            mdl.byte_io(8'ha5, 1'b1, q, k);
        end
        chk(k, 1'b1, "fourth byte acked");
        mdl.stop_c();
        repeat (8) @(negedge clk);
        chk(commits - c0, 0, "refused write began a cycle");
        chk({busy, sda_oe}, 2'h0, "bus not idle after refusal");
        $display("refusal test done");
    endtask : t_refuse
    initial begin
        repeat (3) @(negedge clk);
        rst = 1'b0;
        repeat (5) @(negedge clk);
        chk({busy, sda_oe, wr_commit}, 3'h0, "reset outputs");
        t_write({8'h0f, 8'ha3, 8'h55});
        t_rec_read();
        t_rec_write();
        t_refuse();
        t_write({8'h96, 8'h00, 8'hff});
        close_out();
    end
endmodule : i2c_bus_recovery_reset_tb
